/* File: design/gain_loop_pkg.sv */
/*
 Shared constants, register map and arithmetic helpers of the gain loop block.
 Assumes a 32-bit APB slave with one word per register, byte address = index * 4.
*/
package gain_loop_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int NLOOP = 2;
   localparam int IN_W = 23;
   localparam int PROD_W = 19;
   localparam int OUT_W = 16;
   localparam int DEC_W = 12;
   localparam int GAIN_W = 12;
   localparam int AVG_DEPTH = 4;

   // -----------------------------------------------------------------
   // Register indices, element 0 is loop a, element 1 is loop b
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_CONTROL [NLOOP] = '{8'h0a, 8'h12};
   localparam logic [7:0] IDX_REQUEST [NLOOP] = '{8'h0b, 8'h14};
   localparam logic [7:0] IDX_INIT_GAIN [NLOOP] = '{8'h0d, 8'h15};
   localparam logic [7:0] IDX_K [NLOOP] = '{8'h0e, 8'h16};
   localparam logic [7:0] IDX_P [NLOOP] = '{8'h0f, 8'h17};
   localparam logic [7:0] IDX_AVG_SCALE [NLOOP] = '{8'h10, 8'h18};
   localparam logic [7:0] IDX_DECIM [NLOOP] = '{8'h11, 8'h19};
   localparam logic [7:0] IDX_GAIN [NLOOP] = '{8'h1c, 8'h1d};

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int CTL_BYPASS = 0;
   localparam int CTL_MODE = 4;
   localparam int CTL_WIDTH_LSB = 5;
   localparam int AVG_MULT_LSB = 0;
   localparam int ATTEN_LSB = 4;
   localparam logic [3:0] ATTEN_MAX = 4'he;
   localparam logic [7:0] RST_CONTROL = 8'he0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_K = 8'h80;
   localparam logic [11:0] RST_DECIM = 12'h001;
   localparam logic signed [15:0] REF_RMS_LOG = 16'sh1200;

   function automatic logic [7:0] byte_addr(input logic [7:0] idx);
      return {idx[5:0], 2'b00};
   endfunction

   // Output width code 0..7 selects 4, 5, 6, 7, 8, 10, 12 or 16 bits.
   function automatic logic [4:0] width_of(input logic [2:0] code);
      logic [4:0] w;
      w = 5'h04;
      case (code)
         3'h5: w = 5'h0a;
         3'h6: w = 5'h0c;
         3'h7: w = 5'h10;
         default: w = 5'(code) + 5'h04;
      endcase
      return w;
   endfunction

   // Saturates a signed value to a signed range of w bits, w at most 20.
   function automatic logic signed [19:0] sat_to(input logic signed [39:0] v,
                                                 input logic [4:0] w);
      logic signed [39:0] hi;
      logic signed [39:0] lo;
      hi = (40'sh1 <<< (w - 5'h01)) - 40'sh1;
      lo = -hi - 40'sh1;
      if (v > hi)
         return hi[19:0];
      if (v < lo)
         return lo[19:0];
      return v[19:0];
   endfunction

   // Log2 with 6 integer and 8 fraction bits, linear mantissa.
   function automatic logic [13:0] log2_fx(input logic [51:0] v);
      logic [5:0] pos;
      logic [51:0] n;
      pos = 6'h00;
      for (int b = 0; b < 52; b++)
         if (v[b])
            pos = 6'(b);
      n = v << (6'h33 - pos);
      return {pos, n[50:43]};
   endfunction

endpackage

/* File: design/gain_loop_cfg_if.sv */
/*
 Configuration and status carrier between the register slave and the loops.
 Assumes one register slave drives the settings and the datapath returns gains.
*/
`timescale 1ns/100ps
interface gain_loop_cfg_if;
   import gain_loop_pkg::*;
   logic [7:0] control [NLOOP];
   logic [7:0] request [NLOOP];
   logic [7:0] init_gain [NLOOP];
   logic [7:0] k [NLOOP];
   logic [7:0] p [NLOOP];
   logic [7:0] avg_scale [NLOOP];
   logic [11:0] decim [NLOOP];
   logic [11:0] gain [NLOOP];
   modport regs (output control, request, init_gain, k, p, avg_scale, decim,
                 input gain);
   modport loop (input control, request, init_gain, k, p, avg_scale, decim,
                 output gain);
endinterface

/* File: design/gain_loop_regs.sv */
/*
 APB register slave holding the settings of both gain loops.
 Assumes a standard APB master; every access completes one cycle after setup.
*/
`timescale 1ns/100ps
module gain_loop_regs (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Settings to the loops
   gain_loop_cfg_if.regs cfg
);
   import gain_loop_pkg::*;

   logic [31:0] next_rdata;
   logic hit;
   logic wr;

   assign wr = psel & penable & pready & pwrite;

   // -----------------------------------------------------------------
   // Read decode
   // -----------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0;
      hit = 1'b0;
      for (int l = 0; l < NLOOP; l++) begin
         if (paddr == byte_addr(IDX_CONTROL[l])) begin
            hit = 1'b1;
            next_rdata = {24'h0, cfg.control[l]};
         end
         if (paddr == byte_addr(IDX_REQUEST[l])) begin
            hit = 1'b1;
            next_rdata = {24'h0, cfg.request[l]};
         end
         if (paddr == byte_addr(IDX_INIT_GAIN[l])) begin
            hit = 1'b1;
            next_rdata = {24'h0, cfg.init_gain[l]};
         end
         if (paddr == byte_addr(IDX_K[l])) begin
            hit = 1'b1;
            next_rdata = {24'h0, cfg.k[l]};
         end
         if (paddr == byte_addr(IDX_P[l])) begin
            hit = 1'b1;
            next_rdata = {24'h0, cfg.p[l]};
         end
         if (paddr == byte_addr(IDX_AVG_SCALE[l])) begin
            hit = 1'b1;
            next_rdata = {24'h0, cfg.avg_scale[l]};
         end
         if (paddr == byte_addr(IDX_DECIM[l])) begin
            hit = 1'b1;
            next_rdata = {20'h0, cfg.decim[l]};
         end
         if (paddr == byte_addr(IDX_GAIN[l])) begin
            hit = 1'b1;
            next_rdata = {20'h0, cfg.gain[l]};
         end
      end
   end

   // -----------------------------------------------------------------
   // Bus answer, registered at the setup edge
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0 : next_rdata;
            pslverr <= ~hit;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Writes; the gain words are read only and ignore writes
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int l = 0; l < NLOOP; l++) begin
            cfg.control[l] <= RST_CONTROL;
            cfg.request[l] <= RST_BYTE;
            cfg.init_gain[l] <= RST_BYTE;
            cfg.k[l] <= RST_K;
            cfg.p[l] <= RST_BYTE;
            cfg.avg_scale[l] <= RST_BYTE;
            cfg.decim[l] <= RST_DECIM;
         end
      end else if (wr) begin
         for (int l = 0; l < NLOOP; l++) begin
            if (paddr == byte_addr(IDX_CONTROL[l]))
               cfg.control[l] <= pwdata[7:0];
            if (paddr == byte_addr(IDX_REQUEST[l]))
               cfg.request[l] <= pwdata[7:0];
            if (paddr == byte_addr(IDX_INIT_GAIN[l]))
               cfg.init_gain[l] <= pwdata[7:0];
            if (paddr == byte_addr(IDX_K[l]))
               cfg.k[l] <= pwdata[7:0];
            if (paddr == byte_addr(IDX_P[l]))
               cfg.p[l] <= pwdata[7:0];
            if (paddr == byte_addr(IDX_AVG_SCALE[l]))
               cfg.avg_scale[l] <= pwdata[7:0];
            if (paddr == byte_addr(IDX_DECIM[l]))
               cfg.decim[l] <= pwdata[11:0];
         end
      end
   end

endmodule

/* File: design/gain_loop_top.sv */
/*
 Two log-linear automatic gain control loops with their APB register slave.
 Assumes input samples arrive as one-cycle valid strobes from logic on pclk,
 at most one sample per loop every cycle, and no back-pressure on the output.
*/
`timescale 1ns/100ps
// Functional notes
// - Gain stage output saturates to 4, 5, 6, 7, 8, 10, 12 or 16 bits.
// - Control bit 0 bypasses the loop; input is clipped to 16 bits.
// - Control bit 4 selects signal-level (0) or clipping-level (1) tracking.
// - Feedback is pre-clip value, or pre-clip minus post-clip in clip mode.
// - Loop stages: power, error, loop filter, gain multiply, in sequence.
// - Power is I squared plus Q squared.
// - Averaging of 1 to 16384 samples; update every 1 to 4096 samples.
// - Averaging length is multiple 1..4 of decimation, in bits 1:0.
// - Decimation ratio is a 12-bit register, 1 to 4096.
// - One first-order CIC with history storage, after an attenuator.
// - Attenuation is a right shift of 0 to 14 from a 4-bit field.
// - Decimated power goes to log2; halving the log gives rms.
// - Error is request level minus rms log value.
// - Request level spans 0 to -23.99 dB in 0.094 dB steps.
// - Second-order loop filter K z^-1 / (1-(1+P)z^-1+P z^-2).
// - K and P are 8-bit unsigned fractions, 0 to 0.996.
// - Log gain applied as 8-bit multiply then 4-bit power-of-two shift.
// - Gain products are 19-bit and feed clipping and power.
module gain_loop_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Input samples, one lane per loop
   input wire logic [gain_loop_pkg::NLOOP-1:0] in_valid,
   input wire logic [gain_loop_pkg::NLOOP-1:0][gain_loop_pkg::IN_W-1:0] in_i,
   input wire logic [gain_loop_pkg::NLOOP-1:0][gain_loop_pkg::IN_W-1:0] in_q,
   // Output samples, one lane per loop
   output wire logic [gain_loop_pkg::NLOOP-1:0] out_valid,
   output wire logic [gain_loop_pkg::NLOOP-1:0][gain_loop_pkg::OUT_W-1:0] out_i,
   output wire logic [gain_loop_pkg::NLOOP-1:0][gain_loop_pkg::OUT_W-1:0] out_q
);
   import gain_loop_pkg::*;

   gain_loop_cfg_if cfg ();

   gain_loop_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .cfg(cfg.regs)
   );

   // -----------------------------------------------------------------
   // Gain multiplier
   // -----------------------------------------------------------------
   // The gain word is log2 in 1/256 octave: the top four bits are a signed
   // coarse shift, the low eight a fine mantissa 1 + f/256. A gain word of
   // zero maps the 23-bit input onto the 19-bit product with unity weight.
   function automatic logic signed [18:0] gain_apply(input logic signed [22:0] x,
                                                     input logic [11:0] g);
      logic signed [33:0] prod;
      logic signed [39:0] wide;
      logic [4:0] sh;
      prod = x * $signed({2'b01, g[7:0]});
      sh = 5'h0c - 5'($signed(g[11:8]));
      wide = 40'(prod) >>> sh;
      return 19'(sat_to(wide, 5'(PROD_W)));
   endfunction

   // -----------------------------------------------------------------
   // Per-loop datapath
   // -----------------------------------------------------------------
   for (genvar l = 0; l < NLOOP; l++) begin : g_loop
      logic bypass;
      logic clip_mode;
      logic [4:0] width;
      logic [1:0] mult;
      logic [3:0] atten;
      logic signed [22:0] x_i;
      logic signed [22:0] x_q;
      logic signed [18:0] y_i;
      logic signed [18:0] y_q;
      logic signed [18:0] clip_i;
      logic signed [18:0] clip_q;
      logic signed [18:0] fb_i;
      logic signed [18:0] fb_q;
      logic v1;
      logic v2;
      logic ov;
      logic [15:0] oi;
      logic [15:0] oq;
      logic [37:0] power;
      logic [37:0] scaled;
      logic [49:0] blk;
      logic [11:0] cnt;
      logic last;
      logic [49:0] hist [AVG_DEPTH];
      logic [51:0] avg;
      logic dec_v;
      logic [13:0] lg;
      logic signed [15:0] next_err;
      logic signed [15:0] err;
      logic err_v;
      logic signed [39:0] next_t;
      logic signed [19:0] next_w;
      logic signed [19:0] next_y;
      logic signed [19:0] wv;
      logic signed [19:0] yv;

      assign bypass = cfg.control[l][CTL_BYPASS];
      assign clip_mode = cfg.control[l][CTL_MODE];
      assign width = width_of(cfg.control[l][CTL_WIDTH_LSB +: 3]);
      assign mult = cfg.avg_scale[l][AVG_MULT_LSB +: 2];
      // Larger shift codes behave as the largest legal one.
      assign atten = (cfg.avg_scale[l][ATTEN_LSB +: 4] > ATTEN_MAX) ?
                     ATTEN_MAX : cfg.avg_scale[l][ATTEN_LSB +: 4];

      // The applied gain is the integer part of the filter accumulator.
      assign cfg.gain[l] = yv[19:8];
      assign out_valid[l] = ov;
      assign out_i[l] = oi;
      assign out_q[l] = oq;

      // Stage 1: gain multiplication.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            v1 <= 1'b0;
            x_i <= '0;
            x_q <= '0;
            y_i <= '0;
            y_q <= '0;
         end else begin
            v1 <= in_valid[l];
            if (in_valid[l]) begin
               x_i <= $signed(in_i[l]);
               x_q <= $signed(in_q[l]);
               y_i <= gain_apply($signed(in_i[l]), yv[19:8]);
               y_q <= gain_apply($signed(in_q[l]), yv[19:8]);
            end
         end
      end

      // Stage 2: clipping, output and loop feedback selection.
      assign clip_i = 19'(sat_to(40'(y_i), width));
      assign clip_q = 19'(sat_to(40'(y_q), width));

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            v2 <= 1'b0;
            ov <= 1'b0;
            oi <= '0;
            oq <= '0;
            fb_i <= '0;
            fb_q <= '0;
         end else begin
            v2 <= v1;
            ov <= v1;
            if (v1) begin
               if (bypass) begin
                  oi <= 16'(sat_to(40'(x_i), 5'(OUT_W)));
                  oq <= 16'(sat_to(40'(x_q), 5'(OUT_W)));
               end else begin
                  oi <= clip_i[15:0];
                  oq <= clip_q[15:0];
               end
               // Saturation keeps the sign, so the difference fits 19 bits.
               fb_i <= clip_mode ? y_i - clip_i : y_i;
               fb_q <= clip_mode ? y_q - clip_q : y_q;
            end
         end
      end

      // Stage 3: power, attenuation and first-order integrate and dump.
      assign power = 38'(fb_i * fb_i) + 38'(fb_q * fb_q);
      assign scaled = power >> atten;
      // A ratio register of zero wraps to 4095 and so means 4096.
      assign last = (cnt == cfg.decim[l] - 12'h001);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt <= '0;
            blk <= '0;
            dec_v <= 1'b0;
            for (int i = 0; i < AVG_DEPTH; i++)
               hist[i] <= '0;
         end else begin
            dec_v <= v2 & last;
            if (v2) begin
               if (last) begin
                  cnt <= '0;
                  blk <= '0;
                  hist[0] <= blk + 50'(scaled);
                  for (int i = 1; i < AVG_DEPTH; i++)
                     hist[i] <= hist[i-1];
               end else begin
                  cnt <= cnt + 12'h001;
                  blk <= blk + 50'(scaled);
               end
            end
         end
      end

      // The moving sum over the last mult+1 blocks averages that multiple
      // of the decimation ratio while still updating once per block.
      always_comb begin
         avg = '0;
         for (int i = 0; i < AVG_DEPTH; i++)
            if (i <= int'(mult))
               avg = avg + 52'(hist[i]);
      end

      // Stage 4: log, rms and error. Request steps are four log LSBs of
      // 6.02/256 dB each, that is 0.094 dB, counted downward from the top.
      assign lg = log2_fx(avg);
      assign next_err = REF_RMS_LOG - $signed({6'h00, cfg.request[l], 2'b00})
                        - $signed({3'h0, lg[13:1]});

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            err <= '0;
            err_v <= 1'b0;
         end else begin
            err_v <= dec_v;
            if (dec_v)
               err <= next_err;
         end
      end

      // Stage 5: loop filter as a leaky stage (pole P) into an integrator
      // (pole 1); the gain register supplies the one-update delay.
      assign next_t = (($signed({1'b0, cfg.p[l]}) * 40'(wv)) >>> 8)
                      + $signed({1'b0, cfg.k[l]}) * 40'(err);
      assign next_w = sat_to(next_t, 5'h14);
      assign next_y = sat_to(40'(yv) + 40'(next_w), 5'h14);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            wv <= '0;
            yv <= '0;
         end else if (bypass) begin
            // A bypassed loop rests at the programmed starting gain.
            wv <= '0;
            yv <= {cfg.init_gain[l], 12'h000};
         end else if (err_v) begin
            wv <= next_w;
            yv <= next_y;
         end
      end
   end

endmodule

/* File: tb/gain_loop_top_asserts.sv */
/*
 Port checker of the gain loop top, bound below.
 Assumes loop a control is only written while no sample of loop a is in flight.
*/
`timescale 1ns/100ps
module gain_loop_top_asserts (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Samples
   input wire logic [gain_loop_pkg::NLOOP-1:0] in_valid,
   input wire logic [gain_loop_pkg::NLOOP-1:0][gain_loop_pkg::IN_W-1:0] in_i,
   input wire logic [gain_loop_pkg::NLOOP-1:0][gain_loop_pkg::IN_W-1:0] in_q,
   input wire logic [gain_loop_pkg::NLOOP-1:0] out_valid,
   input wire logic [gain_loop_pkg::NLOOP-1:0][gain_loop_pkg::OUT_W-1:0] out_i,
   input wire logic [gain_loop_pkg::NLOOP-1:0][gain_loop_pkg::OUT_W-1:0] out_q
);
   import gain_loop_pkg::*;
   logic [7:0] ctl_a;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   function automatic logic [15:0] sat16(input logic [22:0] v);
      if ($signed(v) > 23'sh007fff) return 16'h7fff;
      if ($signed(v) < -23'sh008000) return 16'h8000;
      return v[15:0];
   endfunction

   function automatic logic signed [16:0] hi_of(input logic [2:0] c);
      case (c)
         3'h5: return 17'sh001ff;
         3'h6: return 17'sh007ff;
         3'h7: return 17'sh07fff;
         default: return (17'sh1 <<< (c + 3'h3)) - 17'sh1;
      endcase
   endfunction

   // Shadow of the loop a control word, so width and bypass can be judged.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_a <= 8'he0;
      end else if (psel && penable && pready && pwrite && paddr == 8'h28) begin
         ctl_a <= pwdata[7:0];
      end
   end

   property p_lat;
      in_valid[0] |-> ##2 out_valid[0];
   endproperty
   a_lat: assert property (p_lat) else $error("output pulse missing");
   property p_cause;
      out_valid[1] |-> $past(in_valid[1], 2);
   endproperty
   a_cause: assert property (p_cause) else $error("output without sample");
   property p_hold;
      !out_valid[0] |-> $stable(out_i[0]) && $stable(out_q[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("output moved between pulses");
   property p_bypass;
      out_valid[0] && ctl_a[0] |-> out_i[0] == sat16($past(in_i[0], 2));
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass value wrong");
   property p_clip;
      out_valid[0] && !ctl_a[0] |-> $signed({out_q[0][15], out_q[0]}) <= hi_of(ctl_a[7:5])
         && $signed({out_q[0][15], out_q[0]}) >= -hi_of(ctl_a[7:5]) - 17'sh1;
   endproperty
   a_clip: assert property (p_clip) else $error("output beyond width");
   property p_ready;
      psel && !penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_ready_one;
      pready |=> !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready too long");
   property p_unmapped;
      psel && !penable && paddr == 8'hfc |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
   property p_ctl_read;
      psel && penable && pready && !pwrite && paddr == 8'h28 |-> prdata == {24'h0, ctl_a};
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control readback");
endmodule

bind gain_loop_top gain_loop_top_asserts gain_loop_top_asserts_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .out_valid(out_valid),
   .out_i(out_i), .out_q(out_q));

/* File: tb/gain_sink.sv */
/*
 Model of the output port logic: keeps the last sample of each lane.
 Assumes no back-pressure exists, so it only listens.
*/
`timescale 1ns/100ps
module gain_sink (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Output samples
   input wire logic [1:0] out_valid,
   input wire logic [1:0][15:0] out_i,
   input wire logic [1:0][15:0] out_q,
   // Captured values
   output logic [1:0][15:0] got_i,
   output logic [1:0][15:0] got_q
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         got_i <= '0;
         got_q <= '0;
      end else begin
         for (int l = 0; l < 2; l++) begin
            if (out_valid[l]) begin
               got_i[l] <= out_i[l];
               got_q[l] <= out_q[l];
            end
         end
      end
   end
endmodule

/* File: tb/test_log_linear_agc_loop.sv */
/*
 Self-checking bench of the gain loop top: registers, bypass, widths, tracking.
 Assumes the sink model and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
module test_log_linear_agc_loop;
   import gain_loop_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [NLOOP-1:0] in_valid, out_valid;
   logic [NLOOP-1:0][IN_W-1:0] in_i, in_q;
   logic [NLOOP-1:0][OUT_W-1:0] out_i, out_q;
   logic [1:0][15:0] got_i, got_q;
   int failures = 0;
   int checked = 0;

   gain_loop_top gain_loop_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_i(in_i), .in_q(in_q),
      .out_valid(out_valid), .out_i(out_i), .out_q(out_q));
   gain_sink gain_sink_i (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
      .out_i(out_i), .out_q(out_q), .got_i(got_i), .got_q(got_q));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic int wid(input int c);
      return c < 5 ? c + 4 : (c == 5 ? 10 : (c == 6 ? 12 : 16));
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, {idx[5:0], 2'b00}, d, rd, err);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, {idx[5:0], 2'b00}, 32'h0, rd, err);
      chk(rd, exp);
   endtask

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   // The wait covers the output latency and the later gain update.
   task automatic send(input logic [22:0] i, input logic [22:0] q);
      @(posedge pclk);
      in_valid <= 2'b11;
      in_i <= {i, i};
      in_q <= {q, q};
      @(posedge pclk);
      in_valid <= 2'b00;
      repeat (6) @(posedge pclk);
   endtask

   task automatic chk_out(input logic [15:0] ei, input logic [15:0] eq);
      for (int l = 0; l < 2; l++) begin
         chk({16'h0, got_i[l]}, {16'h0, ei});
         chk({16'h0, got_q[l]}, {16'h0, eq});
      end
   endtask

   task automatic t_regs();
      logic [31:0] rd;
      logic err;
      rdchk(IDX_CONTROL[0], 32'he0);
      rdchk(IDX_K[1], 32'h80);
      rdchk(IDX_DECIM[0], 32'h1);
      rdchk(IDX_REQUEST[1], 32'h0);
      wr(IDX_DECIM[1], 32'hffffffff);
      rdchk(IDX_DECIM[1], 32'hfff);
      wr(IDX_AVG_SCALE[0], 32'h123456e3);
      rdchk(IDX_AVG_SCALE[0], 32'he3);
      wr(IDX_GAIN[0], 32'h5a5);
      rdchk(IDX_GAIN[0], 32'h0);
      apb(1'b0, 8'hfc, 32'h0, rd, err);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask

   task automatic t_bypass();
      for (int l = 0; l < 2; l++) begin
         wr(IDX_CONTROL[l], 32'h01);
      end
      send(23'h3fffff, 23'h400000);
      chk_out(16'h7fff, 16'h8000);
      send(23'h001234, 23'h7ffedc);
      chk_out(16'h1234, 16'hfedc);
   endtask

   task automatic t_widths();
      logic [15:0] hi;
      for (int l = 0; l < 2; l++) begin
         wr(IDX_K[l], 32'h0);
      end
      for (int c = 0; c < 8; c++) begin
         hi = 16'((32'h1 << (wid(c) - 1)) - 1);
         for (int l = 0; l < 2; l++) begin
            wr(IDX_CONTROL[l], 32'(c) << 5);
         end
         send(23'h3fffff, 23'h400000);
         chk_out(hi, ~hi);
      end
      send(23'h012340, 23'h7edcc0);
      chk_out(16'h1234, 16'hedcc);
   endtask

   task automatic t_modes();
      for (int m = 0; m < 2; m++) begin
         do_reset();
         for (int l = 0; l < 2; l++) begin
            wr(IDX_CONTROL[l], m ? 32'hf0 : 32'he0);
            wr(IDX_REQUEST[l], 32'h10);
         end
         send(23'h000100, 23'h0);
         for (int l = 0; l < 2; l++) begin
            rdchk(IDX_GAIN[l], m ? 32'h7ff : 32'h6e0);
         end
      end
   endtask

   task automatic t_track();
      do_reset();
      for (int l = 0; l < 2; l++) begin
         wr(IDX_DECIM[l], 32'h4);
      end
      // Loop b drops its power by two bits, so its rms log and its cut are smaller.
      wr(IDX_AVG_SCALE[1], 32'h20);
      for (int s = 0; s < 3; s++) begin
         send(23'h3fffff, 23'h3fffff);
      end
      rdchk(IDX_GAIN[0], 32'h0);
      send(23'h3fffff, 23'h3fffff);
      rdchk(IDX_GAIN[0], 32'hf40);
      rdchk(IDX_GAIN[1], 32'hfc0);
   endtask

   task automatic give_verdict();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      give_verdict();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      in_valid = 2'b00;
      in_i = '0;
      in_q = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_bypass();
      t_widths();
      t_modes();
      t_track();
      give_verdict();
   end
endmodule
